/* rtl/apg_pkg.sv */
/*
  Shared constants and types for the axis pulse train generator.
  Assumes a single 40 MHz system clock and an APB register port.
*/
package apg_pkg;
  // system clock rate in Hz
  localparam int CLK_HZ = 40_000_000;
  // reverse sign lead time in microseconds, and its cycle count
  localparam int SIGN_LEAD_US = 100;
  localparam int SIGN_LEAD_CYC = (CLK_HZ / 1_000_000) * SIGN_LEAD_US;
  // acceleration update interval in milliseconds, and its cycle count
  localparam int ACC_TICK_MS = 1;
  localparam int ACC_TICK_CYC_DEF = (CLK_HZ / 1000) * ACC_TICK_MS;
  // number of axes; three fast inputs are wired per axis
  localparam int AXES_DEF = 2;
  // speed change per acceleration interval, pulses/s
  localparam logic [17:0] ACC_STEP_DEF = 18'h003E8;
  // braking distance estimate shift
  localparam int DEC_SHIFT_DEF = 4;
  // address split: axis index above, register offset below
  localparam int AXIS_SHIFT = 5;
  // per-axis register offsets
  localparam logic [4:0] REG_CFG = 5'h00;
  localparam logic [4:0] REG_UPPER = 5'h04;
  localparam logic [4:0] REG_LOWER = 5'h08;
  localparam logic [4:0] REG_SLIM = 5'h0C;
  localparam logic [4:0] REG_BIAS = 5'h10;
  localparam logic [4:0] REG_TSPD = 5'h14;
  localparam logic [4:0] REG_MOVE = 5'h18;
  localparam logic [4:0] REG_POS = 5'h1C;
  // shared input status register
  localparam logic [7:0] REG_INPUTS = 8'h40;
  // control/status field positions
  localparam int CFG_MODE = 0;
  localparam int CFG_DIRSET = 2;
  localparam int CFG_SCURVE = 3;
  localparam int CFG_START = 4;
  localparam int CFG_STOP = 5;
  localparam int CFG_BUSY = 8;
  localparam int CFG_ERR = 9;
  localparam int CFG_LEAD = 10;
  // reset values and setting range
  localparam logic [31:0] UPPER_RST = 32'h7FFFFFFF;
  localparam logic [31:0] LOWER_RST = 32'h80000000;
  localparam logic [17:0] SLIM_RST = 18'h02710;
  localparam logic [17:0] BIAS_RST = 18'h00000;
  localparam logic [17:0] SPEED_MAX = 18'h30D40;
  localparam logic [17:0] SPEED_MIN = 18'h00001;
  // pulse output encodings
  typedef enum logic [1:0] {
    MODE_FR = 2'b00,
    MODE_PS = 2'b01,
    MODE_Q1 = 2'b10,
    MODE_Q4 = 2'b11
  } apg_mode_t;
  // axis motion states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN = 2'b10
  } apg_state_t;
endpackage

/* rtl/apg_pulse_enc.sv */
/*
  Output encoder for one axis: turns quarter-period ticks into the
  two feed lines in the selected encoding.
  Assumes the caller gives a tick per quarter period and its index.
*/
`timescale 1ns/100ps
`default_nettype none
module apg_pulse_enc
  import apg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic dir,
  input wire logic run,
  input wire logic clr,
  input wire logic tick,
  input wire logic [1:0] q,
  output logic feed_a,
  output logic feed_b
);
  // line levels and quadrature phase counter
  typedef struct packed {
    logic a;
    logic b;
    logic [1:0] ph;
  } apg_enc_t;
  apg_enc_t s;
  apg_enc_t n;

  // next line levels
  always_comb
  begin
    n = s;
    if (clr)
    begin
      // fault: every line is driven off
      n = '0;
    end
    else if (!run)
    begin
      // idle: quadrature holds its phase so no stray edge reaches the drive
      if (!mode[1])
      begin
        n.a = 1'b0;
        n.b = 1'b0;
        // phase restarts too, so a later quadrature run starts from the held lines
        n.ph = 2'b00;
      end
    end
    else if (mode == MODE_FR)
    begin
      if (tick)
      begin
        n.a = dir & ~q[1];
        n.b = ~dir & ~q[1];
      end
    end
    else if (mode == MODE_PS)
    begin
      n.b = dir;
      if (tick)
      begin
        n.a = ~q[1];
      end
    end
    else
    begin
      // x1 steps every quarter, x4 once per command pulse
      if (tick && (mode == MODE_Q1 || q == 2'b00))
      begin
        n.ph = dir ? s.ph + 2'b01 : s.ph - 2'b01;
      end
      n.a = n.ph[1] ^ n.ph[0];
      n.b = n.ph[1];
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign feed_a = s.a;
  assign feed_b = s.b;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_fr_route: assert property (run && !clr && mode == MODE_FR && dir |=> !feed_b)
    else $error("reverse line active during forward run");
  a_ps_sign: assert property (run && !clr && mode == MODE_PS |=> feed_b == $past(dir))
    else $error("sign line does not follow direction");
  a_quad_lag: assert property (mode[1] && run && $stable(dir) && $rose(feed_a)
    |-> feed_b == !dir)
    else $error("quadrature phase order wrong");
  a_q4_edges: assert property (mode == MODE_Q4 && $stable(mode) && !$past(clr)
    && $past(run) && ($changed(feed_a) || $changed(feed_b))
    |-> $past(tick) && $past(q) == 2'b00)
    else $error("x4 edge outside a command pulse boundary");
endmodule
`default_nettype wire

/* rtl/apg_top.sv */
/*
  Axis pulse train generator: APB registers, speed shaping, position
  tracking, stroke checks and one output encoder per axis.
  Assumes APB master on pclk; fast_inputs high means the input element
  conducts. Each axis uses three fast inputs: ready, upper, lower.
*/
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - conducting input reads on, else off
// - positioning reads inputs as negative logic
// - four output encodings, forward/reverse default
// - forward pulses on forward line only
// - sign on reverse line, pulses on forward line
// - reverse sign leads first pulse by 100us
// - quadrature: B lags forward, A lags reverse
// - x1 four edges, x4 one edge per pulse
// - direction setting picks position count sense
// - signed stroke limits, full range defaults
// - equal stroke limits disable the check
// - speed limit 1..200000, default 10000
// - any speed above limit is clamped
// - start floor speed is minimum speed
// - trapezoid or S-curve, trapezoid default
// - on error outputs are cleared
// - independent parameter set per axis
module apg_top
  import apg_pkg::*;
#(
  parameter int AX = AXES_DEF,
  parameter int ACC_TICK_CYC = ACC_TICK_CYC_DEF,
  parameter logic [17:0] ACC_STEP = ACC_STEP_DEF,
  parameter int DEC_SHIFT = DEC_SHIFT_DEF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [5:0] fast_inputs,
  input wire logic [9:0] standard_inputs,
  output logic [AX-1:0] feed_out_f,
  output logic [AX-1:0] feed_out_r,
  output logic [AX-1:0] axis_busy,
  output logic [AX-1:0] axis_error
);
  // s-curve jerk: the per-interval step grows by this much
  localparam logic [17:0] JERK = (ACC_STEP >> 3) == 18'h00000 ? 18'h00001 : ACC_STEP >> 3;

  // whole block state; one array entry per axis
  typedef struct packed {
    apg_state_t [AX-1:0] st;
    apg_mode_t [AX-1:0] mode;
    logic [AX-1:0] dirset;
    logic [AX-1:0] scurve;
    logic [AX-1:0] err;
    logic [AX-1:0] dir;
    logic [AX-1:0][31:0] upper;
    logic [AX-1:0][31:0] lower;
    logic [AX-1:0][31:0] pos;
    logic [AX-1:0][31:0] rem;
    logic [AX-1:0][31:0] move;
    logic [AX-1:0][17:0] slim;
    logic [AX-1:0][17:0] bias;
    logic [AX-1:0][17:0] tspd;
    logic [AX-1:0][17:0] spd;
    logic [AX-1:0][17:0] inc;
    logic [AX-1:0][25:0] nco;
    logic [AX-1:0][1:0] q;
    logic [AX-1:0][11:0] lead;
    logic [15:0] tick;
    logic [31:0] prdata;
  } apg_regs_t;
  apg_regs_t r;
  apg_regs_t n;

  logic [AX-1:0] enc_tick; // quarter step handed to the encoder
  logic [AX-1:0] issue; // a command pulse starts this cycle
  logic [AX-1:0] up; // this pulse counts position upward
  logic [AX-1:0] sw_viol; // next position leaves the stroke window
  logic [AX-1:0][17:0] floor_v; // effective minimum speed
  logic mapped; // address hits a register

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = r.prdata;

  // address decode
  always_comb
  begin
    if (paddr == REG_INPUTS)
    begin
      mapped = 1'b1;
    end
    else if (int'(paddr[7:AXIS_SHIFT]) < AX && paddr[1:0] == 2'b00)
    begin
      mapped = 1'b1;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // next state for the bus, the timer and every axis
  always_comb
  begin
    logic wr;
    logic hit;
    logic flt;
    logic brk;
    logic qt;
    logic [4:0] off;
    logic [17:0] tg;
    logic [17:0] gl;
    logic [17:0] stp;
    logic [18:0] sum;
    logic [26:0] acc;
    logic [31:0] nx;
    logic [31:0] rd;
    logic [31:0] mag;
    wr = psel & penable & pwrite;
    hit = 1'b0;
    flt = 1'b0;
    brk = 1'b0;
    qt = 1'b0;
    off = paddr[4:0];
    tg = '0;
    gl = '0;
    stp = '0;
    sum = '0;
    acc = '0;
    nx = '0;
    rd = '0;
    mag = '0;
    n = r;
    enc_tick = '0;
    issue = '0;
    up = '0;
    sw_viol = '0;
    floor_v = '0;
    // acceleration interval timer, shared by all axes
    n.tick = (r.tick == 16'(ACC_TICK_CYC - 1)) ? 16'h0000 : r.tick + 16'h0001;
    // shared input status; conducting inputs read as on
    if (psel && !penable && !pwrite && paddr == REG_INPUTS)
    begin
      rd = {16'h0000, standard_inputs, fast_inputs};
    end
    for (int a = 0; a < AX; a++)
    begin
      hit = (int'(paddr[7:AXIS_SHIFT]) == a);
      // floor never above the limit, and at least one pulse/s to move
      floor_v[a] = (r.bias[a] > r.slim[a]) ? r.slim[a] : r.bias[a];
      if (floor_v[a] < SPEED_MIN)
      begin
        floor_v[a] = SPEED_MIN;
      end
      // commanded speed clamped between floor and limit
      tg = (r.tspd[a] > r.slim[a]) ? r.slim[a] : r.tspd[a];
      tg = (tg < floor_v[a]) ? floor_v[a] : tg;
      // rough braking estimate: start slowing near the end of the move
      brk = r.rem[a] <= {14'h0000, (r.spd[a] - floor_v[a]) >> DEC_SHIFT};
      gl = brk ? floor_v[a] : tg;
      // position sense and stroke window check
      up[a] = r.dir[a] ^ r.dirset[a];
      nx = up[a] ? r.pos[a] + 32'h00000001 : r.pos[a] - 32'h00000001;
      sw_viol[a] = (r.upper[a] != r.lower[a])
        && ($signed(nx) > $signed(r.upper[a]) || $signed(nx) < $signed(r.lower[a]));
      // an off input means not ready or limit reached
      flt = !fast_inputs[3*a]
        || (r.dir[a] && !fast_inputs[3*a+1]) || (!r.dir[a] && !fast_inputs[3*a+2]);
      // motion sequencing
      case (r.st[a])
        ST_LEAD:
        begin
          // sign already off; wait before the first reverse pulse
          if (r.lead[a] == 12'h000)
          begin
            n.st[a] = ST_RUN;
          end
          else
          begin
            n.lead[a] = r.lead[a] - 12'h001;
          end
        end
        ST_RUN:
        begin
          // speed ramp once per interval
          if (r.tick == 16'h0000)
          begin
            stp = r.scurve[a] ? r.inc[a] : ACC_STEP;
            if (r.spd[a] == gl)
            begin
              n.inc[a] = '0;
            end
            else
            begin
              n.inc[a] = (r.inc[a] + JERK > ACC_STEP) ? ACC_STEP : r.inc[a] + JERK;
            end
            if (r.spd[a] < gl)
            begin
              sum = {1'b0, r.spd[a]} + {1'b0, stp};
              n.spd[a] = (sum > {1'b0, gl}) ? gl : sum[17:0];
            end
            else if (r.spd[a] > gl)
            begin
              n.spd[a] = (r.spd[a] - gl < stp) ? gl : r.spd[a] - stp;
            end
          end
          // rate generator: four quarter ticks per pulse at spd pulses/s
          acc = {1'b0, r.nco[a]} + {7'h00, r.spd[a], 2'b00};
          qt = acc >= 27'(CLK_HZ);
          n.nco[a] = qt ? 26'(acc - 27'(CLK_HZ)) : acc[25:0];
          if (qt && r.q[a] != 2'b11)
          begin
            n.q[a] = r.q[a] + 2'b01;
            enc_tick[a] = 1'b1;
          end
          else if (qt && r.rem[a] == 32'h00000000)
          begin
            // last pulse has completed its period
            n.st[a] = ST_IDLE;
          end
          else if (qt && sw_viol[a])
          begin
            n.err[a] = 1'b1;
            n.st[a] = ST_IDLE;
          end
          else if (qt)
          begin
            n.q[a] = 2'b00;
            n.pos[a] = nx;
            n.rem[a] = r.rem[a] - 32'h00000001;
            enc_tick[a] = 1'b1;
            issue[a] = 1'b1;
          end
        end
        default:
        begin
          n.st[a] = ST_IDLE;
        end
      endcase
      // register writes
      if (wr && hit)
      begin
        if (off == REG_CFG)
        begin
          if (pwdata[CFG_ERR])
          begin
            n.err[a] = 1'b0;
          end
          if (r.st[a] == ST_IDLE)
          begin
            n.mode[a] = apg_mode_t'(pwdata[CFG_MODE+:2]);
            n.dirset[a] = pwdata[CFG_DIRSET];
            n.scurve[a] = pwdata[CFG_SCURVE];
          end
          if (pwdata[CFG_STOP])
          begin
            n.st[a] = ST_IDLE;
          end
          else if (pwdata[CFG_START] && r.st[a] == ST_IDLE && !r.err[a]
                   && r.move[a] != 32'h00000000)
          begin
            mag = r.move[a][31] ? 32'h00000000 - r.move[a] : r.move[a];
            n.dir[a] = ~r.move[a][31];
            n.rem[a] = mag;
            n.spd[a] = floor_v[a];
            n.inc[a] = '0;
            n.nco[a] = '0;
            n.q[a] = 2'b11;
            n.lead[a] = 12'(SIGN_LEAD_CYC - 1);
            n.st[a] = (r.mode[a] == MODE_PS && r.move[a][31]) ? ST_LEAD : ST_RUN;
          end
        end
        else if (off == REG_UPPER)
        begin
          n.upper[a] = pwdata;
        end
        else if (off == REG_LOWER)
        begin
          n.lower[a] = pwdata;
        end
        else if (off == REG_SLIM)
        begin
          // setting range 1..200000
          n.slim[a] = (pwdata > {14'h0000, SPEED_MAX}) ? SPEED_MAX
            : (pwdata == 32'h00000000) ? SPEED_MIN : pwdata[17:0];
        end
        else if (off == REG_BIAS)
        begin
          n.bias[a] = (pwdata > {14'h0000, SPEED_MAX}) ? SPEED_MAX : pwdata[17:0];
        end
        else if (off == REG_TSPD)
        begin
          // a new speed while running is clamped like any other
          n.tspd[a] = (pwdata > {14'h0000, SPEED_MAX}) ? SPEED_MAX : pwdata[17:0];
        end
        else if (off == REG_MOVE)
        begin
          n.move[a] = pwdata;
        end
        else if (off == REG_POS && r.st[a] == ST_IDLE)
        begin
          n.pos[a] = pwdata;
        end
      end
      // speed always held at or below the limit, and at or above the floor while running, even after a limit change
      if (n.spd[a] > n.slim[a])
      begin
        n.spd[a] = n.slim[a];
      end
      else if (n.st[a] == ST_RUN && n.spd[a] < floor_v[a])
      begin
        n.spd[a] = floor_v[a];
      end
      // faults win over any write in the same cycle
      if (r.st[a] != ST_IDLE && flt)
      begin
        n.err[a] = 1'b1;
        n.st[a] = ST_IDLE;
      end
      // read data captured in the setup cycle
      if (psel && !penable && !pwrite && hit)
      begin
        if (off == REG_CFG)
        begin
          rd[CFG_MODE+:2] = r.mode[a];
          rd[CFG_DIRSET] = r.dirset[a];
          rd[CFG_SCURVE] = r.scurve[a];
          rd[CFG_BUSY] = r.st[a] != ST_IDLE;
          rd[CFG_ERR] = r.err[a];
          rd[CFG_LEAD] = r.st[a] == ST_LEAD;
        end
        else if (off == REG_UPPER)
        begin
          rd = r.upper[a];
        end
        else if (off == REG_LOWER)
        begin
          rd = r.lower[a];
        end
        else if (off == REG_SLIM)
        begin
          rd = {14'h0000, r.slim[a]};
        end
        else if (off == REG_BIAS)
        begin
          rd = {14'h0000, r.bias[a]};
        end
        else if (off == REG_TSPD)
        begin
          rd = {14'h0000, r.tspd[a]};
        end
        else if (off == REG_MOVE)
        begin
          rd = r.move[a];
        end
        else if (off == REG_POS)
        begin
          rd = r.pos[a];
        end
      end
    end
    if (psel && !penable && !pwrite)
    begin
      n.prdata = rd;
    end
  end

  // state register with documented defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.upper <= {AX{UPPER_RST}};
      r.lower <= {AX{LOWER_RST}};
      r.slim <= {AX{SLIM_RST}};
      r.bias <= {AX{BIAS_RST}};
    end
    else
    begin
      r <= n;
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one encoder and its checks per axis
  for (genvar g = 0; g < AX; g++)
  begin : g_ax
    logic [12:0] lead_seen; // cycles spent in the sign lead
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        lead_seen <= '0;
      end
      else
      begin
        lead_seen <= (r.st[g] == ST_LEAD) ? lead_seen + 13'h0001 : 13'h0000;
      end
    end

    apg_pulse_enc u_enc (
      .pclk(pclk),
      .presetn(presetn),
      .mode(r.mode[g]),
      .dir(r.dir[g]),
      .run(r.st[g] != ST_IDLE),
      .clr(r.err[g]),
      .tick(enc_tick[g]),
      .q(n.q[g]),
      .feed_a(feed_out_f[g]),
      .feed_b(feed_out_r[g])
    );
    assign axis_busy[g] = r.st[g] != ST_IDLE;
    assign axis_error[g] = r.err[g];

    sequence s_rev_run;
      $rose(r.st[g] == ST_RUN) && r.mode[g] == MODE_PS && !r.dir[g];
    endsequence
    a_lead_wait: assert property (s_rev_run |-> lead_seen == 13'(SIGN_LEAD_CYC)
      && $past(lead_seen) == 13'(SIGN_LEAD_CYC - 1))
      else $error("reverse pulse before sign lead elapsed");
    a_speed_cap: assert property (r.st[g] == ST_RUN && $stable(r.slim[g])
      |-> r.spd[g] <= r.slim[g])
      else $error("speed above limit");
    a_floor_hold: assert property (r.st[g] == ST_RUN && $stable(floor_v[g])
      |-> r.spd[g] >= floor_v[g])
      else $error("speed below start floor");
    a_stroke_off: assert property (r.upper[g] == r.lower[g] |-> !sw_viol[g])
      else $error("stroke check active with equal limits");
    a_pos_step: assert property (issue[g] |=> r.pos[g] == ($past(up[g])
      ? $past(r.pos[g]) + 32'h00000001 : $past(r.pos[g]) - 32'h00000001))
      else $error("position moved the wrong way");
    a_err_clear: assert property ($rose(r.err[g]) |=> !feed_out_f[g] && !feed_out_r[g])
      else $error("outputs not cleared on error");
    a_ready_off: assert property (r.st[g] != ST_IDLE && !fast_inputs[3*g]
      |=> r.err[g] && r.st[g] == ST_IDLE)
      else $error("motion continued with drive not ready");
  end
endmodule
`default_nettype wire

/* sim/apg_drive_model.sv */
/*
  Drive unit model for one axis: watches the two command lines and
  counts pulses, edges and timing gaps; reports its ready input.
  Assumes registered command lines from the pulse generator on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module apg_drive_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_a,
  input wire logic line_b,
  input wire logic fault,
  output logic ready,
  output int rises_a,
  output int rises_b,
  output int edges,
  output int period,
  output int lead,
  output logic b_at_a
);
  logic pa; // previous level of line a
  logic pb; // previous level of line b
  int since_a; // cycles since the last rise of a
  int since_b; // cycles since the last fall of b
  // ready means the element conducts, so a fault reads as off
  assign ready = !fault;
  // counters only grow; the bench takes differences, so no clear is needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa <= 1'b0;
      pb <= 1'b0;
      rises_a <= 0;
      rises_b <= 0;
      edges <= 0;
      period <= 0;
      lead <= 0;
      since_a <= 0;
      since_b <= 0;
      b_at_a <= 1'b0;
    end
    else
    begin
      pa <= line_a;
      pb <= line_b;
      since_a <= since_a + 1;
      since_b <= since_b + 1;
      edges <= edges + int'(line_a ^ pa) + int'(line_b ^ pb);
      // a rise of a: note the spacing and the level of b
      if (line_a && !pa)
      begin
        rises_a <= rises_a + 1;
        period <= since_a;
        since_a <= 1;
        lead <= since_b;
        b_at_a <= line_b;
      end
      if (line_b && !pb)
        rises_b <= rises_b + 1;
      // fall of b restarts the lead count
      if (!line_b && pb)
        since_b <= 1;
    end
  end
endmodule
`default_nettype wire

/* sim/tb_axis_pulse_train_generator.sv */
/*
  Self-checking bench for the pulse generator: APB master, position
  model and two drive unit models.
  Assumes apg_top with a shortened acceleration interval.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_axis_pulse_train_generator;
  import apg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, use_rnd, lerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [5:0] fin_rnd, fast_inputs;
  logic [9:0] standard_inputs;
  logic [1:0] feed_f, feed_r, busy, err, fault, rdy, bat;
  int ra[2], rb[2], ed[2], per[2], ld[2];
  int pos[2]; // model of the position counters
  int fail_count, n_checks, seed, k, a0, n;
  int tax[8] = '{0, 0, 0, 0, 0, 0, 0, 1};
  logic [1:0] tm[8] = '{MODE_FR, MODE_FR, MODE_PS, MODE_PS, MODE_Q1, MODE_Q1, MODE_Q4, MODE_FR};
  logic tds[8] = '{0, 0, 0, 0, 0, 0, 0, 1};
  int tn[8] = '{3, -1, 2, -2, 2, -1, 4, -2};
  // limit inputs stay on; ready comes from the drive models
  assign fast_inputs = use_rnd ? fin_rnd : {2'b11, rdy[1], 2'b11, rdy[0]};
  apg_top #(.ACC_TICK_CYC(40)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .fast_inputs(fast_inputs),
    .standard_inputs(standard_inputs), .feed_out_f(feed_f), .feed_out_r(feed_r),
    .axis_busy(busy), .axis_error(err));
  for (genvar g = 0; g < 2; g++)
  begin : g_drv
    apg_drive_model i_drv (.pclk(pclk), .presetn(presetn), .line_a(feed_f[g]),
      .line_b(feed_r[g]), .fault(fault[g]), .ready(rdy[g]), .rises_a(ra[g]),
      .rises_b(rb[g]), .edges(ed[g]), .period(per[g]), .lead(ld[g]), .b_at_a(bat[g]));
  end
  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [7:0] rg(int ax, logic [4:0] r);
    return 8'(ax * 32) | 8'(r);
  endfunction
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // error response is kept as sampled in the access phase
  task automatic chk(logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, rv, lerr);
    `CHK(rv, x)
  endtask
  // bounded wait until the axis is idle again
  task automatic wait_idle(int ax);
    int t;
    t = 0;
    repeat (2) @(posedge pclk);
    while (busy[ax] !== 1'b0 && t < 30000)
    begin
      @(posedge pclk);
      t++;
    end
    if (busy[ax] !== 1'b0)
    begin
      fail_count++;
      test_done();
    end
  endtask
  // one move; position and line activity judged against the model
  task automatic run(int ax, logic [1:0] m, logic ds, int nn);
    int an, b0, e0, p0;
    an = nn < 0 ? -nn : nn;
    wr(rg(ax, REG_CFG), {29'h0, ds, m});
    wr(rg(ax, REG_MOVE), nn);
    p0 = ra[ax];
    b0 = rb[ax];
    e0 = ed[ax];
    wr(rg(ax, REG_CFG), {27'h0, 1'b1, 1'b0, ds, m});
    wait_idle(ax);
    pos[ax] += ds ? -nn : nn;
    chk(rg(ax, REG_POS), pos[ax]);
    case (m)
      MODE_FR:
      begin
        `CHK(ra[ax] - p0, nn > 0 ? an : 0)
        `CHK(rb[ax] - b0, nn < 0 ? an : 0)
      end
      MODE_PS:
      begin
        `CHK(ra[ax] - p0, an)
        `CHK(bat[ax], 1'(nn > 0))
      end
      MODE_Q1:
      begin
        `CHK(ed[ax] - e0, 4 * an)
        `CHK(bat[ax], 1'(nn < 0))
      end
      default: `CHK(ed[ax] - e0, an)
    endcase
  endtask
  // main sequence
  initial
  begin
    {psel, penable, pwrite, use_rnd} = 4'h0;
    {paddr, pwdata, fin_rnd, standard_inputs, fault} = '0;
    fail_count = 0;
    n_checks = 0;
    seed = 91387;
    pos = '{0, 0};
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int ax = 0; ax < 2; ax++)
    begin
      chk(rg(ax, REG_CFG), 32'h0);
      chk(rg(ax, REG_UPPER), UPPER_RST);
      chk(rg(ax, REG_LOWER), LOWER_RST);
      chk(rg(ax, REG_SLIM), 32'(SLIM_RST));
      chk(rg(ax, REG_BIAS), 32'(BIAS_RST));
      chk(rg(ax, REG_POS), 32'h0);
    end
    for (int ax = 0; ax < 2; ax++)
    begin
      wr(rg(ax, REG_SLIM), 32'h0);
      chk(rg(ax, REG_SLIM), 32'h1);
      chk(rg(1 - ax, REG_SLIM), ax == 0 ? 32'h2710 : 32'h30D40);
      wr(rg(ax, REG_SLIM), 32'h493E0);
      chk(rg(ax, REG_SLIM), 32'h30D40);
      wr(rg(ax, REG_BIAS), 32'h493E0);
      chk(rg(ax, REG_BIAS), 32'h30D40);
      wr(rg(ax, REG_TSPD), 32'h493E0);
      chk(rg(ax, REG_TSPD), 32'h30D40);
    end
    @(posedge pclk);
    use_rnd <= 1'b1;
    fin_rnd <= 6'($random(seed));
    standard_inputs <= 10'($random(seed));
    @(posedge pclk);
    chk(REG_INPUTS, {16'h0, standard_inputs, fin_rnd});
    use_rnd <= 1'b0;
    chk(8'h44, 32'h0);
    `CHK(lerr, 1'b1)
    for (int i = 0; i < 8; i++)
    begin
      run(tax[i], tm[i], tds[i], tn[i]);
      if (i == 0)
        `CHK(per[0], CLK_HZ / 200000)
      if (i == 3)
        `CHK(ld[0] >= SIGN_LEAD_CYC, 1'b1)
    end
    wr(rg(0, REG_CFG), 32'h0);
    wr(rg(0, REG_MOVE), 32'd50);
    wr(rg(0, REG_CFG), 32'h10);
    a0 = ra[0];
    for (k = 0; k < 3000 && ra[0] < a0 + 2; k++)
      @(posedge pclk);
    if (ra[0] < a0 + 2)
    begin
      fail_count++;
      test_done();
    end
    fault[0] <= 1'b1;
    for (k = 0; k < 5 && err[0] !== 1'b1; k++)
      @(posedge pclk);
    @(posedge pclk);
    `CHK(err[0], 1'b1)
    `CHK({feed_f[0], feed_r[0], busy[0]}, 3'b000)
    pos[0] += ra[0] - a0;
    chk(rg(0, REG_POS), pos[0]);
    fault[0] <= 1'b0;
    wr(rg(0, REG_CFG), 32'h200);
    chk(rg(0, REG_CFG), 32'h0);
    wr(rg(0, REG_UPPER), pos[0] + 1);
    wr(rg(0, REG_LOWER), pos[0] - 10);
    wr(rg(0, REG_MOVE), 32'd3);
    wr(rg(0, REG_CFG), 32'h10);
    wait_idle(0);
    `CHK(err[0], 1'b1)
    pos[0] += 1;
    chk(rg(0, REG_POS), pos[0]);
    wr(rg(0, REG_CFG), 32'h200);
    wr(rg(0, REG_UPPER), pos[0]);
    wr(rg(0, REG_LOWER), pos[0]);
    n = 1 + ($random(seed) & 3);
    run(0, MODE_FR, 1'b0, n);
    `CHK(err[0], 1'b0)
    // s-curve move on the second axis
    wr(rg(1, REG_CFG), 32'h8);
    chk(rg(1, REG_CFG), 32'h8);
    wr(rg(1, REG_MOVE), 32'd2);
    wr(rg(1, REG_CFG), 32'h18);
    wait_idle(1);
    pos[1] += 2;
    chk(rg(1, REG_POS), pos[1]);
    test_done();
  end
endmodule
`default_nettype wire
